/* common/golc_pkg.sv */
/*
 Constants for the gain/offset conditioning loop: register map, field layout,
 reset values and loop scaling. Assumes a 32-bit APB register slave.
*/
`default_nettype none
package golc_pkg;
	localparam logic [11:0] GOLC_ADDR_CFG    = 12'h000;
	localparam logic [11:0] GOLC_ADDR_STATUS = 12'h004;
	localparam logic [11:0] GOLC_ADDR_SIN    = 12'h008;
	localparam logic [11:0] GOLC_ADDR_COS    = 12'h00C;
	localparam int GOLC_HYS_MSB  = 7;
	localparam int GOLC_HYS_LSB  = 5;
	localparam int GOLC_OFF_MSB  = 4;
	localparam int GOLC_OFF_LSB  = 3;
	localparam int GOLC_GAIN_MSB = 2;
	localparam int GOLC_GAIN_LSB = 1;
	localparam int GOLC_DIS_BIT  = 0;
	localparam int GOLC_QEN_BIT  = 8;
	localparam logic [8:0] GOLC_CFG_RESET = 9'h12A;
	localparam int GOLC_SAMPLE_W = 16;
	localparam int GOLC_ACC_W    = 24;
	localparam int GOLC_BASE_SHIFT = 7;
	localparam int GOLC_OFF_FRAC   = 8;
	localparam int GOLC_GAIN_FRAC  = 14;
	localparam logic [23:0] GOLC_GAIN_RESET = 24'h004000;
	localparam logic [15:0] GOLC_GAIN_TARGET = 16'h4000;
endpackage
`default_nettype wire

/* rtl/golc_loop.sv */
/*
 Gain/offset controller with digital hysteresis behind an APB slave.
 Assumes sine/cosine samples arrive synchronous to pclk with a valid strobe.
*/
`default_nettype none
module golc_loop
	import golc_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     sample_valid,
	input  wire logic signed [15:0]       sin_in,
	input  wire logic signed [15:0]       cos_in,
	output logic signed [15:0]            sin_out,
	output logic signed [15:0]            cos_out,
	output logic                          quad_enable
);
	typedef struct packed {
		logic [8:0]         cfg;
		logic               qen;
		logic signed [23:0] off_sin;
		logic signed [23:0] off_cos;
		logic        [23:0] gain;
		logic signed [15:0] sin_o;
		logic signed [15:0] cos_o;
		logic [31:0]        rdata;
		logic               armed;
	} golc_state_s;

	golc_state_s st;
	golc_state_s next_st;

	logic               acc;
	logic               mapped;
	logic [2:0]         hys;
	logic [1:0]         oshift;
	logic [1:0]         gshift;
	logic signed [15:0] sin_c;
	logic signed [15:0] cos_c;
	logic signed [31:0] sin_g;
	logic signed [31:0] cos_g;
	logic signed [15:0] sin_n;
	logic signed [15:0] cos_n;
	logic        [15:0] amp;
	logic signed [23:0] gerr;

	assign acc     = psel && penable;
	assign hys     = st.cfg[GOLC_HYS_MSB:GOLC_HYS_LSB];
	assign oshift  = st.cfg[GOLC_OFF_MSB:GOLC_OFF_LSB];
	// Codes 01 and 10 both give a shift of one, matching the documented gain table
	assign gshift  = (st.cfg[GOLC_GAIN_MSB:GOLC_GAIN_LSB] == 2'b11) ? 2'd3 :
		(st.cfg[GOLC_GAIN_MSB:GOLC_GAIN_LSB] == 2'b00) ? 2'd0 : 2'd1;
	assign pready  = 1'b1;
	assign prdata  = st.rdata;
	assign mapped  = (paddr == GOLC_ADDR_CFG) || (paddr == GOLC_ADDR_STATUS)
		|| (paddr == GOLC_ADDR_SIN) || (paddr == GOLC_ADDR_COS);
	// Flagged in the access cycle itself, where the master samples it
	assign pslverr = acc && !mapped;
	assign sin_out = st.sin_o;
	assign cos_out = st.cos_o;
	assign quad_enable = st.qen;

	always_comb
	begin
		sin_c = 16'(sin_in - 16'(st.off_sin >>> GOLC_OFF_FRAC));
		cos_c = 16'(cos_in - 16'(st.off_cos >>> GOLC_OFF_FRAC));
		sin_g = (32'(sin_c) * $signed({8'h00, st.gain})) >>> GOLC_GAIN_FRAC;
		cos_g = (32'(cos_c) * $signed({8'h00, st.gain})) >>> GOLC_GAIN_FRAC;
		sin_n = 16'(sin_g);
		cos_n = 16'(cos_g);
		amp   = 16'((sin_n[15] ? -sin_n : sin_n) + (cos_n[15] ? -cos_n : cos_n));
		gerr  = 24'($signed({1'b0, GOLC_GAIN_TARGET}) - $signed({1'b0, amp}));
	end

	always_comb
	begin
		next_st = st;
		// Captured once; later writes only show in the register
		next_st.armed = 1'b0;
		if (st.armed)
			next_st.qen = st.cfg[GOLC_QEN_BIT];
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				GOLC_ADDR_CFG:    next_st.rdata = {23'h000000, st.cfg};
				GOLC_ADDR_STATUS: next_st.rdata = {31'h00000000, st.qen};
				GOLC_ADDR_SIN:    next_st.rdata = {16'h0000, st.sin_o};
				GOLC_ADDR_COS:    next_st.rdata = {16'h0000, st.cos_o};
				default:          next_st.rdata = 32'h00000000;
			endcase
		end
		if (acc)
		begin
			if (pwrite && paddr == GOLC_ADDR_CFG)
				next_st.cfg = pwdata[8:0];
		end
		if (sample_valid)
		begin
			if (!st.cfg[GOLC_DIS_BIT])
			begin
				// Integrator step grows with code, i.e. faster settling; gain codes 01 and 10 give the same step
				next_st.off_sin = st.off_sin
					+ ((24'(sin_c) <<< oshift) >>> GOLC_BASE_SHIFT);
				next_st.off_cos = st.off_cos
					+ ((24'(cos_c) <<< oshift) >>> GOLC_BASE_SHIFT);
				next_st.gain = 24'($signed(st.gain)
					+ ((gerr <<< gshift) >>> GOLC_BASE_SHIFT));
			end
			if (hys == 3'b000)
			begin
				next_st.sin_o = sin_n;
				next_st.cos_o = cos_n;
			end
			else
			begin
				// Output moves only when change exceeds threshold
				if ((sin_n > st.sin_o + $signed({13'h0000, hys}))
					|| (sin_n < st.sin_o - $signed({13'h0000, hys})))
					next_st.sin_o = sin_n;
				if ((cos_n > st.cos_o + $signed({13'h0000, hys}))
					|| (cos_n < st.cos_o - $signed({13'h0000, hys})))
					next_st.cos_o = cos_n;
			end
		end
	end

	// Quadrature enable is latched only at the first edge after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '{cfg: GOLC_CFG_RESET, gain: GOLC_GAIN_RESET, armed: 1'b1, default: '0};
		else
			st <= next_st;
	end

	property p_bypass;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && hys == 3'b000) |=> (sin_out == $past(sin_n));
	endproperty
	a_bypass: assert property (p_bypass) else $error("hysteresis not bypassed");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && hys != 3'b000
			&& sin_n <= st.sin_o + $signed({13'h0000, hys})
			&& sin_n >= st.sin_o - $signed({13'h0000, hys}))
		|=> $stable(sin_out);
	endproperty
	a_hold: assert property (p_hold) else $error("hysteresis step passed");

	property p_disable;
		@(posedge pclk) disable iff (!presetn)
		(st.cfg[GOLC_DIS_BIT] && !acc) |=> ($stable(st.gain) && $stable(st.off_sin));
	endproperty
	a_disable: assert property (p_disable) else $error("loop ran while disabled");

	property p_qen;
		@(posedge pclk) disable iff (!presetn)
		!st.armed |=> $stable(quad_enable);
	endproperty
	a_qen: assert property (p_qen) else $error("quad enable changed live");

	property p_gshift;
		@(posedge pclk) disable iff (!presetn)
		(st.cfg[GOLC_GAIN_MSB:GOLC_GAIN_LSB] == 2'b10) |-> (gshift == 2'd1);
	endproperty
	a_gshift: assert property (p_gshift) else $error("gain code 10 scale wrong");

	property p_write;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && paddr == GOLC_ADDR_CFG) |=> (st.cfg == $past(pwdata[8:0]));
	endproperty
	a_write: assert property (p_write) else $error("config write lost");

	property p_oshift;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && !st.cfg[GOLC_DIS_BIT] && oshift == 2'b11 && sin_c == -16'sd128)
		|=> (st.off_sin == $past(st.off_sin) - 24'sd8);
	endproperty
	a_oshift: assert property (p_oshift) else $error("offset scale wrong");

	property p_slow;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && !st.cfg[GOLC_DIS_BIT] && oshift == 2'b00 && sin_c == -16'sd128)
		|=> (st.off_sin == $past(st.off_sin) - 24'sd1);
	endproperty
	a_slow: assert property (p_slow) else $error("slowest offset wrong");

	property p_run;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && !st.cfg[GOLC_DIS_BIT] && sin_c[15]) |=> (st.off_sin != $past(st.off_sin));
	endproperty
	a_run: assert property (p_run) else $error("enabled offset loop idle");

	property p_cos_bypass;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && hys == 3'b000) |=> (cos_out == $past(cos_n));
	endproperty
	a_cos_bypass: assert property (p_cos_bypass) else $error("cos hysteresis not bypassed");

	property p_qen_cap;
		@(posedge pclk) disable iff (!presetn)
		st.armed |=> (quad_enable == $past(st.cfg[GOLC_QEN_BIT]));
	endproperty
	a_qen_cap: assert property (p_qen_cap) else $error("quad enable not captured");

	property p_err;
		@(posedge pclk) disable iff (!presetn)
		(acc && paddr[11:4] != 8'h00) |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not flagged");

	c_write: cover property (@(posedge pclk) acc && pwrite);
	c_run:   cover property (@(posedge pclk) sample_valid && !st.cfg[GOLC_DIS_BIT]);
	c_err:   cover property (@(posedge pclk) acc && pslverr);
	c_hys:   cover property (@(posedge pclk) sample_valid && hys == 3'b111);
	c_dis:   cover property (@(posedge pclk) sample_valid && st.cfg[GOLC_DIS_BIT]);
endmodule
`default_nettype wire

/* test/golc_sensor_model.sv */
/* Sensor front end model: sine/cosine samples with a one-cycle strobe.
 Assumes pclk from the bench; changes only just after a rising edge. */
`default_nettype none
module golc_sensor_model
(
	output logic               sample_valid,
	output logic signed [15:0] sin_in,
	output logic signed [15:0] cos_in,
	input  wire logic          pclk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sample_valid = 1'b0;
		sin_in = 16'h0000;
		cos_in = 16'h0000;
	end
	// Gap selects a prompt or a slow producer
	task automatic send(input logic [15:0] s, input logic [15:0] c, input int gap);
		repeat (gap) @(posedge pclk);
		sample_valid <= 1'b1;
		sin_in <= s;
		cos_in <= c;
		@(posedge pclk);
		sample_valid <= 1'b0;
		// Stale lines never hold the last value
		sin_in <= ~s;
		cos_in <= ~c;
	endtask
endmodule
`default_nettype wire

/* test/gain_offset_loop_config_test.sv */
/* Self-checking bench for the conditioning loop.
 Assumes the zero-wait APB slave and registered outputs of the design. */
`default_nettype none
module gain_offset_loop_config_test
	import golc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, quad_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, exp_q[$], msk_q[$];
	logic signed [15:0] sin_in, cos_in, sin_out, cos_out, smp;
	int err_total, check_count;
	golc_loop DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sin_in(sin_in), .cos_in(cos_in),
		.sin_out(sin_out), .cos_out(cos_out), .quad_enable(quad_enable));
	golc_sensor_model sensor (.sample_valid(sample_valid), .sin_in(sin_in),
		.cos_in(cos_in), .pclk(pclk));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			err_total++;
			$display("ERROR %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Quad bit always written inverted to show it is not taken live
	function automatic logic [31:0] cfg(input logic [2:0] h, input logic [1:0] o, g);
		return {23'h0, ~GOLC_CFG_RESET[GOLC_QEN_BIT], h, o, g, 1'b1};
	endfunction
	// Reads carry the expected word in d and a compare mask in m
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, m);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
		begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
	endtask
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	always @(posedge pclk)
	begin
		logic [31:0] m;
		if (psel && penable && pready)
			check({31'h0, pslverr}, {31'h0, paddr[11:4] != 8'h00});
		if (psel && penable && pready && !pwrite && msk_q.size() > 0)
		begin
			m = msk_q.pop_front();
			check(prdata & m, exp_q.pop_front() & m);
		end
	end
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial
	begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(17));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, GOLC_ADDR_CFG, {23'h0, GOLC_CFG_RESET}, 32'h1FF);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, GOLC_ADDR_CFG, cfg(3'(k), 2'(k), 2'(3 - k)), '0);
			apb(1'b0, GOLC_ADDR_CFG, cfg(3'(k), 2'(k), 2'(3 - k)), 32'h1FF);
		end
		apb(1'b0, GOLC_ADDR_STATUS, {31'h0, GOLC_CFG_RESET[GOLC_QEN_BIT]}, 32'h1);
		apb(1'b1, 12'h0F0, 32'hFFFFFFFF, '0);
		apb(1'b0, 12'h0F0, '0, 32'hFFFFFFFF);
		// Slowest speeds while the loop is off; hysteresis bypassed first, then set to 7
		apb(1'b1, GOLC_ADDR_CFG, cfg(3'b000, 2'b00, 2'b00), '0);
		idle(1);
		smp = 16'($urandom_range(0, 16383)) - 16'sd8192;
		sensor.send(smp, -smp, 0);
		idle(4);
		apb(1'b0, GOLC_ADDR_SIN, {16'h0, smp}, 32'hFFFF);
		apb(1'b0, GOLC_ADDR_COS, {16'h0, -smp}, 32'hFFFF);
		apb(1'b1, GOLC_ADDR_CFG, cfg(3'b111, 2'b00, 2'b00), '0);
		idle(1);
		sensor.send(smp + 16'sd7, 16'h0000, 3);
		idle(4);
		apb(1'b0, GOLC_ADDR_SIN, {16'h0, smp}, 32'hFFFF);
		idle(1);
		sensor.send(smp + 16'sd8, 16'h0000, 0);
		idle(4);
		apb(1'b0, GOLC_ADDR_SIN, {16'h0, smp + 16'sd8}, 32'hFFFF);
		// Loop running: first sample still sees unity gain and zero offset
		apb(1'b1, GOLC_ADDR_CFG, cfg(3'b000, 2'b11, 2'b11) ^ 32'h1, '0);
		idle(1);
		sensor.send(-16'sd128, -16'sd128, 0);
		idle(2);
		apb(1'b0, GOLC_ADDR_SIN, {16'h0, -16'sd128}, 32'hFFFF);
		apb(1'b1, GOLC_ADDR_CFG, cfg(3'b000, 2'b00, 2'b00) ^ 32'h1, '0);
		idle(1);
		sensor.send(-16'sd129, -16'sd129, 0);
		idle(2);
		check({31'h0, quad_enable}, {31'h0, GOLC_CFG_RESET[GOLC_QEN_BIT]});
		report_and_stop();
	end
endmodule
`default_nettype wire
